// ### design/cpsc_ctrl.sv
// Power controller end: cluster-off, wakeup enable and status query registers.
// Assumes the cluster agent on cpsc_if and core on/off requests on mclk.
`timescale 1ns/100ps
`include "cpsc_params.svh"

// Notes on behaviour
// [R1] Cluster-off write requests whole cluster power-down
// [R2] Software writes only its own affinity
// [R3] Cluster switches off only its own cluster
// [R4] Wake enable bit gates distributor wake requests
// [R5] Low 24 bits select core to configure
// [R6] Status write selects core, read adds status
// [R7] Bit 31 top level active, else zero
// [R8] Bit 30 cluster level active, else zero
// [R9] Bit 29 selected core powered on
// [R10] Bit 28 mirrors core wake enable
// [R11] Bit 27 pending cluster off until standby
// [R12] Bit 26 pending core off until standby
// [R13] Bits 25:24 last power-on cause code
// [R14] Affinity fields: level 2, 1, 0
// [R15] Cluster pending flag cleared by sleep or wake
// [R16] Reserved bits read zero, writes ignored
module cpsc_ctrl #(
  parameter int                  N_CORES      = 4,
  parameter logic [7:0]          TOP_ID       = 8'h00,
  parameter logic [7:0]          CLUSTER_ID   = 8'h00,
  parameter logic                HAS_TOP_LVL  = 1'b0,
  parameter logic [N_CORES-1:0]  STARTUP_MASK = '1
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  cpsc_if.dev                     bus,
  input  wire logic [N_CORES-1:0] core_off_req,
  input  wire logic [N_CORES-1:0] core_on_req,
  input  wire logic               warm_reset,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cpsc_pkg::cpsc_aff_t        clu_off_aff;
  cpsc_pkg::cpsc_aff_t        wake_aff;
  cpsc_pkg::cpsc_aff_t        query_aff;
  logic [N_CORES-1:0]         core_on;
  logic [N_CORES-1:0]         wen;
  logic [N_CORES-1:0]         pend_core;
  logic                       pend_clu;
  logic                       clu_on;
  cpsc_pkg::cpsc_cause_t      cause [N_CORES];
  logic [`CPSC_IRQ_W-1:0]     irq_stat;
  logic [`CPSC_IRQ_W-1:0]     irq_mask;
  cpsc_pkg::cpsc_word_t       rdata;

  function automatic logic clu_match(input cpsc_pkg::cpsc_aff_t a);
    clu_match = (a[`CPSC_AFF2_HI:`CPSC_AFF2_LO] == TOP_ID) &&
                (a[`CPSC_AFF1_HI:`CPSC_AFF1_LO] == CLUSTER_ID);  // [R14]
  endfunction

  function automatic logic core_match(input cpsc_pkg::cpsc_aff_t a);
    core_match = clu_match(a) && (32'(a[`CPSC_AFF0_HI:`CPSC_AFF0_LO]) < N_CORES);
  endfunction

  logic [7:0] wake_idx;
  logic [7:0] off_idx;
  logic [7:0] q_idx;
  assign wake_idx = bus.wdata[`CPSC_AFF0_HI:`CPSC_AFF0_LO];
  assign off_idx  = bus.wdata[`CPSC_AFF0_HI:`CPSC_AFF0_LO];
  assign q_idx    = query_aff[`CPSC_AFF0_HI:`CPSC_AFF0_LO];

  logic wr_off;
  logic wr_wake;
  logic wr_query;
  logic wr_stat;
  logic wr_mask;
  assign wr_off   = bus.wr && (bus.addr == `CPSC_OFS_CLU_OFF);
  assign wr_wake  = bus.wr && (bus.addr == `CPSC_OFS_WAKE_CFG);
  assign wr_query = bus.wr && (bus.addr == `CPSC_OFS_STATUS);
  assign wr_stat  = bus.wr && (bus.addr == `CPSC_OFS_IRQ_STAT);
  assign wr_mask  = bus.wr && (bus.addr == `CPSC_OFS_IRQ_MASK);

  // Off request only honoured for a powered-on core of this cluster
  logic off_ok;
  assign off_ok = wr_off && core_match(bus.wdata[`CPSC_AFF_W-1:0])
                  && core_on[off_idx[$clog2(N_CORES)-1:0]];  // [R1]

  // Cluster drops while its standby is high with the request pending
  logic clu_down;
  assign clu_down = pend_clu && bus.cluster_idle_standby;  // [R11]

  // ----------------------------------------------------------------
  // Per-core power state
  // ----------------------------------------------------------------
  logic [N_CORES-1:0] wake_go;
  logic [N_CORES-1:0] on_go;
  logic [N_CORES-1:0] off_go;

  for (genvar i = 0; i < N_CORES; i++) begin : g_core
    assign wake_go[i] = bus.wake_req[i] && wen[i] && !core_on[i];  // [R4]
    assign on_go[i]   = core_on_req[i] && !core_on[i];
    assign off_go[i]  = pend_core[i] && bus.core_idle_standby[i];  // [R12]

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        core_on[i] <= STARTUP_MASK[i];
        cause[i]   <= `CPSC_CAUSE_COLD;
      end else if (warm_reset) begin
        core_on[i] <= STARTUP_MASK[i];
        cause[i]   <= STARTUP_MASK[i] ? `CPSC_CAUSE_PIN : cause[i];  // [R13]
      end else if (on_go[i]) begin
        core_on[i] <= 1'b1;
        cause[i]   <= `CPSC_CAUSE_CORE_ON;  // [R13]
      end else if (wake_go[i]) begin
        core_on[i] <= 1'b1;
        cause[i]   <= `CPSC_CAUSE_WAKE;  // [R13]
      end else if (clu_down || off_go[i]) begin
        core_on[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pend_core[i] <= 1'b0;
      end else if (warm_reset || off_go[i] || !core_on[i]) begin
        pend_core[i] <= 1'b0;
      end else if (core_off_req[i]) begin
        pend_core[i] <= 1'b1;  // [R12]
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        wen[i] <= 1'b0;
      end else if (wr_wake && core_match(bus.wdata[`CPSC_AFF_W-1:0])
                   && (wake_idx == 8'(i))) begin
        wen[i] <= bus.wdata[`CPSC_WEN_BIT];  // [R5]
      end
    end
  end

  // ----------------------------------------------------------------
  // Cluster state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_clu <= 1'b0;
    end else if (warm_reset || clu_down || (|wake_go) || (|on_go)) begin
      pend_clu <= 1'b0;  // [R15]
    end else if (off_ok) begin
      pend_clu <= 1'b1;  // [R1] [R15]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clu_on <= |STARTUP_MASK;
    end else if (warm_reset) begin
      clu_on <= |STARTUP_MASK;
    end else if ((|wake_go) || (|on_go)) begin
      clu_on <= 1'b1;
    end else if (clu_down) begin
      clu_on <= 1'b0;  // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Software-visible affinity holders
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clu_off_aff <= '0;
    end else if (wr_off) begin
      clu_off_aff <= bus.wdata[`CPSC_AFF_W-1:0];  // [R16]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_aff <= '0;
    end else if (wr_wake) begin
      wake_aff <= bus.wdata[`CPSC_AFF_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      query_aff <= '0;
    end else if (wr_query) begin
      query_aff <= bus.wdata[`CPSC_AFF_W-1:0];  // [R6]
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle
  logic [`CPSC_IRQ_W-1:0] irq_set;
  assign irq_set[`CPSC_IRQ_CLU_DOWN] = clu_down;
  assign irq_set[`CPSC_IRQ_WOKEN]    = |wake_go;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= `CPSC_IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~(wr_stat ? bus.wdata[`CPSC_IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `CPSC_IRQ_RST;
    end else if (wr_mask) begin
      irq_mask <= bus.wdata[`CPSC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat & ~(wr_stat ? bus.wdata[`CPSC_IRQ_W-1:0] : '0) | irq_set)
               & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [$clog2(N_CORES)-1:0] qi;
  logic [$clog2(N_CORES)-1:0] wi;
  logic                       q_core;
  logic                       q_clu;
  assign qi     = q_idx[$clog2(N_CORES)-1:0];
  assign wi     = wake_aff[$clog2(N_CORES)-1:0];
  assign q_core = core_match(query_aff);
  assign q_clu  = clu_match(query_aff);

  cpsc_pkg::cpsc_word_t status_word;
  assign status_word = {
    HAS_TOP_LVL && q_clu && clu_on,  // [R7]
    q_clu && clu_on,                 // [R8]
    q_core && core_on[qi],           // [R9]
    q_core && wen[qi],               // [R10]
    q_clu && pend_clu,               // [R11]
    q_core && pend_core[qi],         // [R12]
    q_core ? cause[qi] : `CPSC_CAUSE_COLD,  // [R13]
    query_aff                        // [R6]
  };

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `CPSC_WORD_RST;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `CPSC_OFS_CLU_OFF:  rdata <= {`CPSC_RSVD_AFF_W'(0), clu_off_aff};  // [R16]
        `CPSC_OFS_WAKE_CFG: rdata <= {core_match(wake_aff) && wen[wi],
                                      `CPSC_RSVD_WAKE_W'(0), wake_aff};  // [R16]
        `CPSC_OFS_STATUS:   rdata <= status_word;
        `CPSC_OFS_IRQ_STAT: rdata <= {{(32-`CPSC_IRQ_W){1'b0}}, irq_stat};
        `CPSC_OFS_IRQ_MASK: rdata <= {{(32-`CPSC_IRQ_W){1'b0}}, irq_mask};
        default:            rdata <= `CPSC_WORD_RST;
      endcase
    end else begin
      rdata <= `CPSC_WORD_RST;
    end
  end

  assign bus.rdata       = rdata;
  assign bus.core_pwr    = core_on;
  assign bus.cluster_pwr = clu_on;

endmodule

// ### pkg/cpsc_params.svh
// Constants of the cluster power status control block.
// Assumes inclusion by bare name from the package and both ends.
`ifndef CPSC_PARAMS_SVH
`define CPSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CPSC_ADDR_W        8
`define CPSC_OFS_CLU_OFF   8'h08
`define CPSC_OFS_WAKE_CFG  8'h0c
`define CPSC_OFS_STATUS    8'h10
`define CPSC_OFS_IRQ_STAT  8'h14
`define CPSC_OFS_IRQ_MASK  8'h18

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define CPSC_AFF_W         24
`define CPSC_AFF2_HI       23
`define CPSC_AFF2_LO       16
`define CPSC_AFF1_HI       15
`define CPSC_AFF1_LO       8
`define CPSC_AFF0_HI       7
`define CPSC_AFF0_LO       0
`define CPSC_WEN_BIT       31
`define CPSC_RSVD_WAKE_W   7
`define CPSC_RSVD_AFF_W    8

// ----------------------------------------------------------------
// Power-on cause codes
// ----------------------------------------------------------------
`define CPSC_CAUSE_COLD    2'h0
`define CPSC_CAUSE_PIN     2'h1
`define CPSC_CAUSE_CORE_ON 2'h2
`define CPSC_CAUSE_WAKE    2'h3

// ----------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------
`define CPSC_IRQ_W         2
`define CPSC_IRQ_CLU_DOWN  0
`define CPSC_IRQ_WOKEN     1
`define CPSC_IRQ_RST       2'h0
`define CPSC_WORD_RST      32'h0000_0000

`endif

// ### pkg/cpsc_pkg.sv
// Types shared by both ends of the cluster power status control block.
// Assumes cpsc_params.svh on the include path.
`include "cpsc_params.svh"

package cpsc_pkg;

  typedef logic [`CPSC_AFF_W-1:0] cpsc_aff_t;
  typedef logic [1:0]             cpsc_cause_t;
  typedef logic [31:0]            cpsc_word_t;

endpackage

// ### pkg/cpsc_if.sv
// Link between the cluster agent and the power controller.
// Assumes one clock; the testbench supplies it and joins both ends.
`timescale 1ns/100ps
`include "cpsc_params.svh"

interface cpsc_if #(
  parameter int N_CORES = 4
);
  logic                     wr;
  logic                     rd;
  logic [`CPSC_ADDR_W-1:0]  addr;
  cpsc_pkg::cpsc_word_t     wdata;
  cpsc_pkg::cpsc_word_t     rdata;
  logic [N_CORES-1:0]       core_idle_standby;
  logic                     cluster_idle_standby;
  logic [N_CORES-1:0]       wake_req;
  logic [N_CORES-1:0]       core_pwr;
  logic                     cluster_pwr;

  modport dev (
    input  wr, rd, addr, wdata, core_idle_standby, cluster_idle_standby, wake_req,
    output rdata, core_pwr, cluster_pwr
  );
  modport host (
    output wr, rd, addr, wdata, core_idle_standby, cluster_idle_standby, wake_req,
    input  rdata, core_pwr, cluster_pwr
  );
endinterface

// ### design/cpsc_host.sv
// Cluster-side agent: forwards software accesses, standby and wake levels.
// Assumes software port and core signals on mclk; the controller answers in one cycle.
`timescale 1ns/100ps
`include "cpsc_params.svh"

module cpsc_host #(
  parameter int                   N_CORES  = 4,
  parameter cpsc_pkg::cpsc_aff_t  SELF_AFF = 24'h00_0000
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  cpsc_if.host                         bus,
  input  wire logic [`CPSC_ADDR_W-1:0] sw_addr,
  input  wire cpsc_pkg::cpsc_word_t    sw_wdata,
  input  wire logic                    sw_wr,
  input  wire logic                    sw_rd,
  output cpsc_pkg::cpsc_word_t         sw_rdata,
  input  wire logic [N_CORES-1:0]      core_wfi,
  input  wire logic                    cluster_wfi,
  input  wire logic [N_CORES-1:0]      dist_wake,
  output logic                         prog_error
);

  // ----------------------------------------------------------------
  // Request filter
  // ----------------------------------------------------------------
  // Only the requester's own affinity may switch its cluster off
  logic bad_off;
  assign bad_off = sw_wr && (sw_addr == `CPSC_OFS_CLU_OFF)
                   && (sw_wdata[`CPSC_AFF_W-1:0] != SELF_AFF);  // [R2] [R3]

  // Strobes pass straight on so the read answer keeps its one-cycle slot
  assign bus.wr    = sw_wr && !bad_off;
  assign bus.rd    = sw_rd;
  assign bus.addr  = sw_addr;
  assign bus.wdata = {`CPSC_RSVD_AFF_W'(0), sw_wdata[`CPSC_AFF_W-1:0]} |
                     (sw_wdata & {1'b1, 31'h0000_0000});  // [R14]
  assign sw_rdata  = bus.rdata;

  assign bus.core_idle_standby    = core_wfi;
  assign bus.cluster_idle_standby = cluster_wfi;
  assign bus.wake_req             = dist_wake;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_error <= 1'b0;
    end else if (bad_off) begin
      prog_error <= 1'b1;
    end
  end

endmodule

// ### verif/cpsc_asserts.sv
// Checker for one cpsc link: read answers, status fields and power moves.
// Assumes the plain link signals of one cpsc_if, all on mclk.
`timescale 1ns/100ps
`include "cpsc_params.svh"

module cpsc_asserts #(
  parameter int         N_CORES    = 4,
  parameter logic [7:0] TOP_ID     = 8'h00,
  parameter logic [7:0] CLUSTER_ID = 8'h00
) (
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [`CPSC_ADDR_W-1:0] addr,
  input wire cpsc_pkg::cpsc_word_t    wdata,
  input wire cpsc_pkg::cpsc_word_t    rdata,
  input wire logic [N_CORES-1:0]      core_idle_standby,
  input wire logic                    cluster_idle_standby,
  input wire logic [N_CORES-1:0]      wake_req,
  input wire logic [N_CORES-1:0]      core_pwr,
  input wire logic                    cluster_pwr
);
  // ----------------------------------------------------------------
  // Shadow of the selected core, wake enables and pending cluster off
  // ----------------------------------------------------------------
  logic [23:0]        sel;
  logic [N_CORES-1:0] wen;
  logic [N_CORES-1:0] wake_go;
  logic               pc;
  logic               hit;
  logic               clu_hit;
  logic               sel_pwr;
  logic               sel_wen;
  assign clu_hit = sel[23:8] == {TOP_ID, CLUSTER_ID};
  assign hit     = clu_hit && sel[7:0] < N_CORES;
  assign sel_pwr = core_pwr[sel[7:0]];
  assign sel_wen = wen[sel[7:0]];
  assign wake_go = wake_req & wen & ~core_pwr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sel <= 24'h0;
    else if (wr && addr == 8'h10) sel <= wdata[23:0];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wen <= '0;
    else if (wr && addr == 8'h0c && wdata[23:8] == {TOP_ID, CLUSTER_ID} && wdata[7:0] < N_CORES)
      wen[wdata[7:0]] <= wdata[31];
  end

  // Any core coming up also cancels the pending cluster off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pc <= 1'b0;
    else if (!cluster_pwr || wake_go != '0 || (core_pwr & ~$past(core_pwr)) != '0)
      pc <= 1'b0;
    else if (wr && addr == 8'h08 && wdata[23:8] == {TOP_ID, CLUSTER_ID}
             && wdata[7:0] < N_CORES && core_pwr[wdata[7:0]]) pc <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_rd_quiet; !rd |=> rdata == 32'h0; endproperty
  property p_echo; rd && addr == 8'h10 |=> rdata[23:0] == sel; endproperty
  property p_top_raz; rd && addr == 8'h10 |=> !rdata[31]; endproperty
  property p_mid; rd && addr == 8'h10 && hit |=> rdata[30] == $past(cluster_pwr); endproperty
  property p_base; rd && addr == 8'h10 && hit |=> rdata[29] == $past(sel_pwr); endproperty
  property p_wen; rd && addr == 8'h10 && hit |=> rdata[28] == $past(sel_wen); endproperty
  // Only a foreign cluster blanks every status bit; a bad core index keeps cluster bits
  property p_miss; rd && addr == 8'h10 && !clu_hit |=> rdata[31:24] == 8'h0; endproperty
  property p_rsvd; rd && (addr == 8'h08 || addr == 8'h0c) |=> rdata[30:24] == 7'h0; endproperty
  property p_down; pc && cluster_idle_standby |=> !cluster_pwr && core_pwr == '0; endproperty
  property p_wake; wake_go != '0 |=> (core_pwr & $past(wake_go)) == $past(wake_go); endproperty

  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
  a_echo: assert property (p_echo) else $error("status affinity not echoed");
  a_top_raz: assert property (p_top_raz) else $error("top level bit not zero");
  a_mid: assert property (p_mid) else $error("cluster level bit wrong");
  a_base: assert property (p_base) else $error("core power bit wrong");
  a_wen: assert property (p_wen) else $error("wake enable alias wrong");
  a_miss: assert property (p_miss) else $error("foreign query shows status");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  a_down: assert property (p_down) else $error("cluster did not power down");
  a_wake: assert property (p_wake) else $error("enabled wake ignored");

  c_wake: cover property (wake_go != '0);
  c_down: cover property (pc && cluster_idle_standby);
  c_stat: cover property (rd && addr == 8'h10 && hit);
endmodule

// ### verif/tb_top.sv
// Self-checking bench: host agent and controller joined by one link.
// Assumes package, interface and both design ends compiled first.
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", nm, e, g); fail_count++; end end

module tb_top;
  localparam logic [23:0] SELF = 24'h00_0102;
  logic        mclk, rst_n, sw_wr, sw_rd, cluster_wfi, warm_reset, prog_error, irq;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, rv, w;
  logic [3:0]  core_wfi, dist_wake, core_off_req, core_on_req;
  int          fail_count = 0;
  int          n_checks = 0;

  cpsc_if #(.N_CORES(4)) cpsc_if_inst ();
  cpsc_host #(.N_CORES(4), .SELF_AFF(SELF)) cpsc_host_inst (
    .mclk(mclk), .rst_n(rst_n), .bus(cpsc_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .core_wfi(core_wfi),
    .cluster_wfi(cluster_wfi), .dist_wake(dist_wake), .prog_error(prog_error));
  cpsc_ctrl #(.N_CORES(4), .CLUSTER_ID(8'h01)) cpsc_ctrl_inst (
    .mclk(mclk), .rst_n(rst_n), .bus(cpsc_if_inst), .core_off_req(core_off_req),
    .core_on_req(core_on_req), .warm_reset(warm_reset), .irq(irq));
  cpsc_asserts #(.N_CORES(4), .CLUSTER_ID(8'h01)) cpsc_asserts_inst (
    .mclk(mclk), .rst_n(rst_n), .wr(cpsc_if_inst.wr), .rd(cpsc_if_inst.rd),
    .addr(cpsc_if_inst.addr), .wdata(cpsc_if_inst.wdata), .rdata(cpsc_if_inst.rdata),
    .core_idle_standby(cpsc_if_inst.core_idle_standby),
    .cluster_idle_standby(cpsc_if_inst.cluster_idle_standby),
    .wake_req(cpsc_if_inst.wake_req), .core_pwr(cpsc_if_inst.core_pwr),
    .cluster_pwr(cpsc_if_inst.cluster_pwr));

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_stat(input logic [23:0] a, input logic [6:0] st);
    return {1'b0, st, a};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(negedge mclk);
    rv = sw_rdata;
  endtask

  // st is {mid, base, wen, cluster pend, core pend, cause}
  task automatic stat(input logic [23:0] a, input logic [6:0] st);
    wr_reg(8'h10, {8'h00, a});
    rd_reg(8'h10);
    `CHK("status", exp_stat(a, st), rv)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Nothing here waits on the design, so a plain time limit suffices
  initial begin
    #2000000;
    fail_count++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    {sw_wr, sw_rd, cluster_wfi, warm_reset, sw_addr, sw_wdata} = '0;
    {core_wfi, dist_wake, core_off_req, core_on_req} = '0;
    void'($urandom(32'h8cb2));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    stat(SELF, 7'b1100000);
    rd_reg(8'h40);
    `CHK("unmapped", 32'h0, rv)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      wr_reg(8'h0c, {w[31:24], 16'h0001, i[7:0]});
      rd_reg(8'h0c);
      `CHK("wake cfg", {w[31], 7'h0, 16'h0001, i[7:0]}, rv)
      stat({16'h0001, i[7:0]}, {2'b11, w[31], 4'h0});
    end
    for (int i = 0; i < 4; i++) wr_reg(8'h0c, {i == 1, 15'h0, 8'h01, i[7:0]});
    stat(24'h00_0200, 7'h0);
    // Random levels: nothing pending and every core on, so power must not move
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      w = $urandom;
      {cluster_wfi, core_wfi, dist_wake} <= w[8:0];
    end
    @(posedge mclk);
    {cluster_wfi, core_wfi, dist_wake} <= 9'h000;
    cyc(1);
    `CHK("idle pwr", 5'h1f, {cpsc_if_inst.cluster_pwr, cpsc_if_inst.core_pwr})
    $display("test wake enable done");
    @(posedge mclk);
    core_off_req <= 4'h1;
    @(posedge mclk);
    core_off_req <= 4'h0;
    stat(24'h00_0100, 7'b1100100);
    @(posedge mclk);
    core_wfi <= 4'h1;
    @(posedge mclk);
    core_wfi <= 4'h0;
    cyc(1);
    `CHK("core pwr", 4'he, cpsc_if_inst.core_pwr)
    stat(24'h00_0100, 7'b1000000);
    @(posedge mclk);
    core_on_req <= 4'h1;
    @(posedge mclk);
    core_on_req <= 4'h0;
    stat(24'h00_0100, 7'b1100010);
    $display("test core off on done");
    @(posedge mclk);
    core_off_req <= 4'ha;
    core_wfi <= 4'ha;
    @(posedge mclk);
    core_off_req <= 4'h0;
    @(posedge mclk);
    core_wfi <= 4'h0;
    dist_wake <= 4'ha;
    @(posedge mclk);
    dist_wake <= 4'h0;
    cyc(1);
    `CHK("wake pwr", 4'h7, cpsc_if_inst.core_pwr)
    stat(24'h00_0101, 7'b1110011);
    rd_reg(8'h14);
    `CHK("irq stat", 32'h2, rv)
    wr_reg(8'h18, 32'h2);
    cyc(2);
    `CHK("irq on", 1'b1, irq)
    wr_reg(8'h14, 32'h2);
    cyc(2);
    `CHK("irq off", 1'b0, irq)
    $display("test wake done");
    wr_reg(8'h08, 32'h0000_0202);
    stat(SELF, 7'b1100000);
    `CHK("prog err", 1'b1, prog_error)
    wr_reg(8'h08, {8'hff, SELF});
    stat(SELF, 7'b1101000);
    @(posedge mclk);
    cluster_wfi <= 1'b1;
    @(posedge mclk);
    cluster_wfi <= 1'b0;
    cyc(1);
    `CHK("cluster pwr", 1'b0, cpsc_if_inst.cluster_pwr)
    `CHK("all cores", 4'h0, cpsc_if_inst.core_pwr)
    stat(SELF, 7'b0000000);
    rd_reg(8'h14);
    `CHK("irq down", 32'h1, rv)
    $display("test cluster off done");
    @(posedge mclk);
    warm_reset <= 1'b1;
    @(posedge mclk);
    warm_reset <= 1'b0;
    cyc(2);
    `CHK("cluster up", 1'b1, cpsc_if_inst.cluster_pwr)
    stat(SELF, 7'b1100001);
    $display("test warm reset done");
    final_report();
  end
endmodule
